// ### logic/acmu_pkg.sv
// Purpose: Shared constants for the accumulator convert and move unit
// Assumes: 16-bit memory words, 32-bit accumulator
// Notes: Opcodes are a 4-bit field; an all-zero field is an empty location
package acmu_pkg;

  // Instruction codes
  localparam logic [3:0] OP_IDLE = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_ADDR_LOAD = 4'h2;
  localparam logic [3:0] OP_LABEL_LOAD = 4'h3;
  localparam logic [3:0] OP_BCD_TO_BIN = 4'h4;
  localparam logic [3:0] OP_BIN_TO_BCD = 4'h5;
  localparam logic [3:0] OP_ONES_COMP = 4'h6;
  localparam logic [3:0] OP_TABLE_COPY = 4'h7;
  localparam logic [3:0] OP_PMEM_COPY = 4'h8;
  localparam logic [3:0] OP_SCAN_END = 4'h9;
  localparam logic [3:0] OP_STOP = 4'hA;

  // Memory selectors for the external port and copy ends
  localparam logic SEL_WORD = 1'b0;
  localparam logic SEL_LABEL = 1'b1;

  // Field layout of digit-coded values
  localparam int DIGIT_W = 4;
  localparam int BCD_DIGITS = 8;
  localparam int OCT_DIGITS = 4;
  localparam int OCT_BITS = 3;

  // Values after reset
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Operating modes and copy engine states
  typedef enum logic {MODE_PROGRAM, MODE_RUN} acmu_mode_t;
  typedef enum logic {CPY_IDLE, CPY_MOVE} acmu_cpy_t;

endpackage : acmu_pkg

// ### logic/acmu_fifo.sv
// Purpose: Word FIFO between the copy reader and the copy writer
// Assumes: One clock, synchronous active-high reset
// Notes: Full and empty are exact; no write when full, no read when empty
module acmu_fifo import acmu_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Handshakes; full and empty come straight from the count
  assign o_in_ready = (count_ff != DEPTH[AW:0]);
  assign o_out_valid = (count_ff != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_ff[rd_ptr_ff];

  // Storage has no reset; only occupied entries are ever read
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  // Pointers wrap at depth, which is a power of two
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : acmu_fifo

// ### logic/acmu_core.sv
// Purpose: Accumulator conversions, table copies and scan control
// Assumes: Instructions arrive one per handshake from the scan sequencer
// Notes: Copies run word by word through a FIFO; the core is busy meanwhile
// Contract
// - The BCD-to-binary op replaces the accumulator with its binary value.
// - The binary-to-BCD op replaces the accumulator with its decimal-coded value.
// - The ones-complement op inverts all 32 accumulator bits in place.
// - Table copy moves count-from-stack-1 words from accumulator source to operand destination.
// - An address load pushes the old accumulator into stack level one first.
// - An address load turns an octal operand into hex and puts it in the accumulator.
// - Program-memory copy moves stack-2 words at stack-1 offset from accumulator to operand.
// - The stack-1 offset applies to both the label area and the word-memory block.
// - Offsets start at zero and are never bound-checked, so the program keeps them in range.
// - An empty location acts as a no-op and changes no state.
// - Scan end stops the scan so code placed after it does not run in the main scan.
// - Without a scan end in the program, run entry is refused with an error.
// - Scan end is unconditional and an input contact on it is not accepted.
// - The stop op switches from run to program mode and halts execution.
module acmu_core import acmu_pkg::*; #(
  parameter int WORD_AW = 8,
  parameter int LABEL_AW = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_OP_VALID,
  input wire logic [3:0] I_OPCODE,
  input wire logic [15:0] I_OPERAND,
  input wire logic I_RUNG_POWER,
  input wire logic I_HAS_CONTACT,
  output logic O_OP_READY,
  input wire logic I_RUN_REQ,
  input wire logic I_END_PRESENT,
  input wire logic I_SCAN_START,
  input wire logic I_MEM_WE,
  input wire logic I_MEM_SEL,
  input wire logic [15:0] I_MEM_ADDR,
  input wire logic [15:0] I_MEM_WDATA,
  output logic [15:0] O_MEM_RDATA,
  output logic [31:0] O_ACC,
  output logic [31:0] O_STACK1,
  output logic [31:0] O_STACK2,
  output logic O_RUN_MODE,
  output logic O_SCAN_DONE,
  output logic O_BUSY,
  output logic O_ERROR
);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion helpers
  // Digit-coded to binary, most significant nibble first
  function automatic logic [31:0] bcd_to_bin(input logic [31:0] v);
    logic [31:0] acc = '0;
    for (int i = BCD_DIGITS - 1; i >= 0; i--) begin
      acc = 32'((acc * 32'h0000_000A) + {28'h0, v[i*DIGIT_W +: DIGIT_W]});
    end
    return acc;
  endfunction : bcd_to_bin
  // Binary to digit-coded by shift and add-three; high digits beyond eight drop
  function automatic logic [31:0] bin_to_bcd(input logic [31:0] v);
    logic [31:0] bcd = '0;
    for (int b = 31; b >= 0; b--) begin
      for (int d = 0; d < BCD_DIGITS; d++) begin
        if (bcd[d*DIGIT_W +: DIGIT_W] > 4'h4) begin
          bcd[d*DIGIT_W +: DIGIT_W] = bcd[d*DIGIT_W +: DIGIT_W] + 4'h3;
        end
      end
      bcd = {bcd[30:0], v[b]};
    end
    return bcd;
  endfunction : bin_to_bcd
  // Octal digits held one per nibble packed into a plain binary address
  function automatic logic [31:0] oct_to_hex(input logic [15:0] v);
    logic [31:0] r = '0;
    for (int i = 0; i < OCT_DIGITS; i++) begin
      r[i*OCT_BITS +: OCT_BITS] = v[i*DIGIT_W +: OCT_BITS];
    end
    return r;
  endfunction : oct_to_hex

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] acc_ff, stack1_ff, stack2_ff;
  logic acc_is_label_ff, past_end_ff, error_ff, scan_done_ff, src_sel_ff, dst_sel_ff;
  acmu_mode_t mode_ff;
  acmu_cpy_t cpy_ff;
  logic [15:0] src_ptr_ff, dst_ptr_ff, rd_left_ff, wr_left_ff, rdata_ff;
  logic [15:0] wmem_ff [2**WORD_AW];
  logic [15:0] lmem_ff [2**LABEL_AW];

  logic op_take, exec_ok, push_op, bad_end, copy_start, copy_last, nxt_src_sel, nxt_dst_sel;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [15:0] nxt_count, nxt_src, nxt_dst, fifo_in_data, fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction acceptance
  // Busy copies hold off the sequencer rather than queue behind it
  assign O_OP_READY = (cpy_ff == CPY_IDLE);
  assign op_take = I_OP_VALID && O_OP_READY;
  // past scan end
  // Ops are only acted on in run mode and before this scan's end
  assign exec_ok = op_take && (mode_ff == MODE_RUN) && !past_end_ff &&
                   (I_RUNG_POWER || I_OPCODE == OP_SCAN_END);
  assign bad_end = op_take && (mode_ff == MODE_RUN) && !past_end_ff &&
                   (I_OPCODE == OP_SCAN_END) && I_HAS_CONTACT;
  assign push_op = exec_ok && (I_OPCODE == OP_LOAD || I_OPCODE == OP_ADDR_LOAD ||
                               I_OPCODE == OP_LABEL_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and stack
  // conversions
  // octal, idle, digits
  // An unknown or empty opcode falls to default and leaves everything alone
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      acc_ff <= ACC_RST;
      acc_is_label_ff <= 1'b0;
    end else if (exec_ok) begin
      case (I_OPCODE)
        OP_LOAD, OP_LABEL_LOAD: begin
          acc_ff <= {16'h0000, I_OPERAND};
          acc_is_label_ff <= (I_OPCODE == OP_LABEL_LOAD);
        end
        OP_ADDR_LOAD: begin
          acc_ff <= oct_to_hex(I_OPERAND);
          acc_is_label_ff <= 1'b0;
        end
        OP_BCD_TO_BIN: acc_ff <= bcd_to_bin(acc_ff);
        OP_BIN_TO_BCD: acc_ff <= bin_to_bcd(acc_ff);
        OP_ONES_COMP: acc_ff <= ~acc_ff;
        default: acc_ff <= acc_ff;
      endcase
    end
  end

  // push before load
  // Every load pushes; the old level two falls off the bottom
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      stack1_ff <= ACC_RST;
      stack2_ff <= ACC_RST;
    end else if (push_op) begin
      stack1_ff <= acc_ff;
      stack2_ff <= stack1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and scan control
  // run entry, stop
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      mode_ff <= MODE_PROGRAM;
    end else if (exec_ok && I_OPCODE == OP_STOP) begin
      mode_ff <= MODE_PROGRAM;
    end else if (I_RUN_REQ && mode_ff == MODE_PROGRAM && I_END_PRESENT) begin
      mode_ff <= MODE_RUN;
    end
  end

  // Error holds until an accepted run entry clears it; a refused run or a contact on the end sets it
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      error_ff <= 1'b0;
    end else if (bad_end || (I_RUN_REQ && mode_ff == MODE_PROGRAM && !I_END_PRESENT)) begin
      error_ff <= 1'b1;
    end else if (I_RUN_REQ && mode_ff == MODE_PROGRAM) begin
      error_ff <= 1'b0;
    end
  end

  // end of scan
  // Labels and routines after the end stay dormant until the next scan start
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      past_end_ff <= 1'b0;
      scan_done_ff <= 1'b0;
    end else begin
      scan_done_ff <= exec_ok && I_OPCODE == OP_SCAN_END && !I_HAS_CONTACT;
      if (exec_ok && I_OPCODE == OP_SCAN_END && !I_HAS_CONTACT) begin
        past_end_ff <= 1'b1;
      end else if (I_SCAN_START || mode_ff == MODE_PROGRAM) begin
        past_end_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Copy setup
  // copy setup
  // shared unchecked offset
  // A label-loaded accumulator picks the label-to-word direction
  always_comb begin
    copy_start = 1'b0;
    nxt_src_sel = SEL_WORD;
    nxt_dst_sel = SEL_WORD;
    nxt_count = stack1_ff[15:0];
    nxt_src = acc_ff[15:0];
    nxt_dst = I_OPERAND;
    if (exec_ok && I_OPCODE == OP_TABLE_COPY) begin
      copy_start = 1'b1;
    end else if (exec_ok && I_OPCODE == OP_PMEM_COPY) begin
      copy_start = 1'b1;
      nxt_count = stack2_ff[15:0];
      nxt_src = 16'(acc_ff[15:0] + stack1_ff[15:0]);
      nxt_dst = 16'(I_OPERAND + stack1_ff[15:0]);
      nxt_src_sel = acc_is_label_ff ? SEL_LABEL : SEL_WORD;
      nxt_dst_sel = acc_is_label_ff ? SEL_WORD : SEL_LABEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Copy engine
  // Reader fills the FIFO; writer drains it into the destination
  assign fifo_in_valid = (cpy_ff == CPY_MOVE) && (rd_left_ff != CNT_RST);
  assign fifo_in_data = (src_sel_ff == SEL_LABEL) ? lmem_ff[src_ptr_ff[LABEL_AW-1:0]]
                                                  : wmem_ff[src_ptr_ff[WORD_AW-1:0]];
  // External writes to the same memory win the port and stall the writer
  assign fifo_out_ready = (cpy_ff == CPY_MOVE) && !(I_MEM_WE && I_MEM_SEL == dst_sel_ff);
  assign copy_last = fifo_out_valid && fifo_out_ready && (wr_left_ff == 16'h0001);

  // A zero count finishes at once without going busy
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      cpy_ff <= CPY_IDLE;
      src_sel_ff <= SEL_WORD;
      dst_sel_ff <= SEL_WORD;
      src_ptr_ff <= CNT_RST;
      dst_ptr_ff <= CNT_RST;
      rd_left_ff <= CNT_RST;
      wr_left_ff <= CNT_RST;
    end else begin
      case (cpy_ff)
        CPY_IDLE: begin
          if (copy_start && nxt_count != CNT_RST) begin
            cpy_ff <= CPY_MOVE;
            src_sel_ff <= nxt_src_sel;
            dst_sel_ff <= nxt_dst_sel;
            src_ptr_ff <= nxt_src;
            dst_ptr_ff <= nxt_dst;
            rd_left_ff <= nxt_count;
            wr_left_ff <= nxt_count;
          end
        end
        CPY_MOVE: begin
          if (fifo_in_valid && fifo_in_ready) begin
            src_ptr_ff <= src_ptr_ff + 16'h0001;
            rd_left_ff <= rd_left_ff - 16'h0001;
          end
          if (fifo_out_valid && fifo_out_ready) begin
            dst_ptr_ff <= dst_ptr_ff + 16'h0001;
            wr_left_ff <= wr_left_ff - 16'h0001;
          end
          if (copy_last) begin
            cpy_ff <= CPY_IDLE;
          end
        end
        default: cpy_ff <= CPY_IDLE;
      endcase
    end
  end

  acmu_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_flush(1'b0),
    .i_in_valid(fifo_in_valid),
    .i_in_data(fifo_in_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memories
  // Word memory: external port or copy writer, never both in one cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_MEM_WE && I_MEM_SEL == SEL_WORD) begin
      wmem_ff[I_MEM_ADDR[WORD_AW-1:0]] <= I_MEM_WDATA;
    end else if (fifo_out_valid && fifo_out_ready && dst_sel_ff == SEL_WORD) begin
      wmem_ff[dst_ptr_ff[WORD_AW-1:0]] <= fifo_out_data;
    end
  end

  // Label area: addresses wrap, so out-of-area offsets read stale words
  always_ff @(posedge I_CLOCK) begin
    if (I_MEM_WE && I_MEM_SEL == SEL_LABEL) begin
      lmem_ff[I_MEM_ADDR[LABEL_AW-1:0]] <= I_MEM_WDATA;
    end else if (fifo_out_valid && fifo_out_ready && dst_sel_ff == SEL_LABEL) begin
      lmem_ff[dst_ptr_ff[LABEL_AW-1:0]] <= fifo_out_data;
    end
  end

  // Registered read port for inspection
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= (I_MEM_SEL == SEL_LABEL) ? lmem_ff[I_MEM_ADDR[LABEL_AW-1:0]]
                                           : wmem_ff[I_MEM_ADDR[WORD_AW-1:0]];
    end
  end

  assign O_MEM_RDATA = rdata_ff;
  assign O_ACC = acc_ff;
  assign O_STACK1 = stack1_ff;
  assign O_STACK2 = stack2_ff;
  assign O_RUN_MODE = (mode_ff == MODE_RUN);
  assign O_SCAN_DONE = scan_done_ff;
  assign O_BUSY = (cpy_ff == CPY_MOVE);
  assign O_ERROR = error_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // decode result
  chk_bcd_to_bin: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_BCD_TO_BIN |=> acc_ff == bcd_to_bin($past(acc_ff)))
    else $error("accumulator not converted to binary");
  chk_bin_to_bcd: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_BIN_TO_BCD |=> bin_to_bcd($past(acc_ff)) == acc_ff)
    else $error("accumulator not converted to decimal");
  chk_ones_comp: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_ONES_COMP |=> (acc_ff ^ $past(acc_ff)) == 32'hFFFF_FFFF)
    else $error("accumulator not fully inverted");
  chk_addr_push: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_ADDR_LOAD |=> stack1_ff == $past(acc_ff) && stack2_ff == $past(stack1_ff))
    else $error("address load did not push the accumulator");
  chk_addr_octal: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_ADDR_LOAD |=> acc_ff == oct_to_hex($past(I_OPERAND)))
    else $error("address load gave wrong hex value");
  chk_idle_hold: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    op_take && I_OPCODE == OP_IDLE && !I_RUN_REQ |=> $stable(acc_ff) && $stable(stack1_ff) && $stable(mode_ff))
    else $error("empty location changed state");
  chk_end_ignored: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    past_end_ff && !I_SCAN_START ##1 past_end_ff |-> $stable(acc_ff) && $stable(stack1_ff))
    else $error("instruction ran after scan end");
  chk_run_refused: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    I_RUN_REQ && mode_ff == MODE_PROGRAM && !I_END_PRESENT |=> mode_ff == MODE_PROGRAM && error_ff)
    else $error("run entered without a scan end");
  chk_stop_mode: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_ok && I_OPCODE == OP_STOP |=> !O_RUN_MODE ##1 !O_RUN_MODE || $past(I_RUN_REQ))
    else $error("stop did not leave run mode");
  chk_copy_busy: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    copy_start && nxt_count != CNT_RST |=> O_BUSY && wr_left_ff == $past(nxt_count) && !O_OP_READY)
    else $error("copy did not start with the stacked count");
endmodule : acmu_core

// ### dv/acmu_core_tb.sv
// Purpose: Self-checking bench for the accumulator convert and move unit
// Assumes: Port contract of the core, 256-word word and label memories
// Notes: Int model is compared after every op; memories read back via port
module acmu_core_tb import acmu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 10;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, pwr = 1'b1, cont = 1'b0;
  logic run_req = 1'b0, end_pres = 1'b0, scan_st = 1'b0, mwe = 1'b0, msel = 1'b0;
  logic [3:0] opc = 4'h0;
  logic [15:0] opnd = 16'h0000, maddr = 16'h0000, mwdata = 16'h0000, rdata;
  logic [31:0] acc, stk1, stk2;
  logic rdy, run_mode, scan_done, busy, error;
  int err_count = 0, check_count = 0;
  int unsigned m_acc, m_s1, m_s2, wmem[256], lmem[256];
  bit m_run, m_past, m_lbl, m_err;

  acmu_core dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_OP_VALID(vld), .I_OPCODE(opc), .I_OPERAND(opnd),
    .I_RUNG_POWER(pwr), .I_HAS_CONTACT(cont), .O_OP_READY(rdy), .I_RUN_REQ(run_req),
    .I_END_PRESENT(end_pres), .I_SCAN_START(scan_st), .I_MEM_WE(mwe), .I_MEM_SEL(msel),
    .I_MEM_ADDR(maddr), .I_MEM_WDATA(mwdata), .O_MEM_RDATA(rdata), .O_ACC(acc), .O_STACK1(stk1),
    .O_STACK2(stk2), .O_RUN_MODE(run_mode), .O_SCAN_DONE(scan_done), .O_BUSY(busy), .O_ERROR(error));

  // Free-running 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Drives land a fixed delay after the edge, never racing the sampler
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask : tick

  function automatic int unsigned bcd2bin(input int unsigned v);
    int unsigned r = 0, w = 1;
    for (int i = 0; i < 8; i++) begin
      r += ((v >> (4 * i)) % 16) * w;
      w *= 10;
    end
    return r;
  endfunction : bcd2bin

  function automatic int unsigned bin2bcd(input int unsigned v);
    int unsigned r = 0;
    for (int i = 0; i < 8; i++) begin
      r |= (v % 10) << (4 * i);
      v /= 10;
    end
    return r;
  endfunction : bin2bcd

  // Block of writes; strobe stays up between words
  task automatic mem_fill(input logic sel, input int lo, input int n);
    for (int i = lo; i < lo + n; i++) begin
      msel = sel;
      maddr = 16'(i);
      mwdata = 16'($urandom);
      mwe = 1'b1;
      if (sel) lmem[i] = mwdata; else wmem[i] = mwdata;
      tick(1);
    end
    mwe = 1'b0;
  endtask : mem_fill

  task automatic mem_cmp(input logic sel, input int lo, input int n);
    for (int i = lo; i < lo + n; i++) begin
      msel = sel;
      maddr = 16'(i);
      tick(1);
      check("mem", rdata, sel ? lmem[i] : wmem[i]);
    end
  endtask : mem_cmp

  task automatic enter_run(input bit endp);
    end_pres = endp;
    run_req = 1'b1;
    tick(1);
    run_req = 1'b0;
    tick(1);
    m_run = m_run | endp;
    m_err = !endp;
    check("run", run_mode, m_run);
    check("error", error, m_err);
  endtask : enter_run

  ////////////////////////////////////////////////////////////////////////////
  // One instruction: drive, update the model, settle, compare
  task automatic exec(input logic [3:0] op, input logic [15:0] arg);
    int n;
    bit eff, sd, wr;
    n = 0;
    wr = 0;
    while (rdy !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    // A ready that never returns counts against the run
    check("ready wait", rdy, 1'b1);
    opc = op;
    opnd = arg;
    vld = 1'b1;
    tick(1);
    vld = 1'b0;
    sd = scan_done;
    eff = m_run && !m_past && (pwr || op == OP_SCAN_END);
    // unknown and empty ops leave state alone
    if (eff) begin
      case (op)
        OP_LOAD, OP_ADDR_LOAD, OP_LABEL_LOAD: begin
          m_s2 = m_s1;
          m_s1 = m_acc;
          m_acc = (op == OP_ADDR_LOAD) ? {arg[14:12], arg[10:8], arg[6:4], arg[2:0]} : arg;
          m_lbl = (op == OP_LABEL_LOAD);
        end
        OP_BCD_TO_BIN: m_acc = bcd2bin(m_acc);
        OP_BIN_TO_BCD: m_acc = bin2bcd(m_acc % 100000000);
        OP_ONES_COMP: m_acc = ~m_acc;
        OP_TABLE_COPY: for (int i = 0; i < 16'(m_s1); i++) wmem[8'(arg + i)] = wmem[8'(m_acc + i)];
        OP_PMEM_COPY: for (int i = 0; i < 16'(m_s2); i++) begin
          if (m_lbl) wmem[8'(arg + m_s1 + i)] = lmem[8'(m_acc + m_s1 + i)];
          else lmem[8'(arg + m_s1 + i)] = wmem[8'(m_acc + m_s1 + i)];
        end
        // contact on scan end is refused
        OP_SCAN_END: if (cont) m_err = 1; else m_past = 1;
        OP_STOP: m_run = 0;
        default: ;
      endcase
    end
    n = 0;
    msel = SEL_WORD;
    maddr = 16'h00F0;
    mwdata = 16'($urandom);
    tick(1);
    sd |= scan_done;
    // copy holds off new ops; a word-memory port write stalls a copy into word memory
    while (busy !== 1'b0 && n < 500) begin
      if (n == 0) check("ready", rdy, 1'b0);
      mwe = (n == 2);
      wr |= (n == 2);
      tick(1);
      n++;
    end
    mwe = 1'b0;
    // A copy that never finishes counts against the run
    check("busy", busy, 1'b0);
    if (wr) wmem[8'hF0] = mwdata;
    check("scan_done", sd, eff && op == OP_SCAN_END && !cont);
    check("acc", acc, m_acc);
    check("stack1", stk1, m_s1);
    check("stack2", stk2, m_s2);
    check("run", run_mode, m_run);
    check("error", error, m_err);
  endtask : exec

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well past the whole sequence
  initial begin
    #(100 * 20000);
    err_count++;
    final_report();
  end

  initial begin
    void'($urandom(44));
    tick(12);
    rst = 1'b0;
    check("ready", rdy, 1'b1);
    exec(OP_LOAD, 16'h1234);
    enter_run(1'b0);
    enter_run(1'b1);
    for (int k = 0; k < 6; k++) begin
      exec(OP_LOAD, 16'($urandom));
      exec(OP_BCD_TO_BIN, 16'h0000);
      exec(OP_BIN_TO_BCD, 16'h0000);
      exec(OP_ONES_COMP, 16'h0000);
      exec(OP_BIN_TO_BCD, 16'h0000);
      exec(OP_BCD_TO_BIN, 16'h0000);
    end
    exec(OP_IDLE, 16'($urandom));
    exec(4'hF, 16'($urandom));
    pwr = 1'b0;
    exec(OP_ONES_COMP, 16'h0000);
    pwr = 1'b1;
    // table copy longer than the FIFO, then one of zero count
    mem_fill(SEL_WORD, 0, 64);
    exec(OP_LOAD, 16'h0014);
    exec(OP_ADDR_LOAD, 16'h0010);
    exec(OP_TABLE_COPY, 16'h0040);
    mem_cmp(SEL_WORD, 64, 20);
    exec(OP_LOAD, 16'h0000);
    exec(OP_ADDR_LOAD, 16'h0020);
    exec(OP_TABLE_COPY, 16'h0041);
    mem_cmp(SEL_WORD, 64, 2);
    // word to label, then label back to word
    exec(OP_LOAD, 16'h0005);
    exec(OP_LOAD, 16'h0003);
    exec(OP_LOAD, 16'h0020);
    exec(OP_PMEM_COPY, 16'h0010);
    mem_cmp(SEL_LABEL, 19, 5);
    exec(OP_LOAD, 16'h0005);
    exec(OP_LOAD, 16'h0000);
    exec(OP_LABEL_LOAD, 16'h0013);
    exec(OP_PMEM_COPY, 16'h0060);
    mem_cmp(SEL_WORD, 96, 5);
    // scan end and what follows it
    cont = 1'b1;
    exec(OP_SCAN_END, 16'h0000);
    cont = 1'b0;
    exec(OP_SCAN_END, 16'h0000);
    exec(OP_ONES_COMP, 16'h0000);
    scan_st = 1'b1;
    tick(1);
    scan_st = 1'b0;
    m_past = 0;
    exec(OP_ONES_COMP, 16'h0000);
    // stop leaves later ops without effect
    exec(OP_STOP, 16'h0000);
    exec(OP_ONES_COMP, 16'h0000);
    final_report();
  end
endmodule : acmu_core_tb
